// ### include/cpm_pkg.sv
/*
 * cpm_pkg: constants, register map and types of the cascaded PI
 * motor controller. Assumes one 250 MHz core clock and a bus master
 * that uses byte addresses on 32-bit aligned words.
 */
`default_nettype none
package cpm_pkg;
    localparam int CLK_PERIOD_PS  = 4000;
    localparam int CTRL_PERIOD_NS = 62500;
    localparam int CYCLE_CNT      = (CTRL_PERIOD_NS * 1000) / CLK_PERIOD_PS;
    localparam int NSTAGE         = 3;
    localparam int STG_POS        = 0;
    localparam int STG_VEL        = 1;
    localparam int STG_CUR        = 2;

    localparam logic signed [63:0] PERMILLE = 64'sh3E8;

    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_LEGACY  = 8'h04;
    localparam logic [7:0] OFS_STATUS  = 8'h08;
    localparam logic [7:0] OFS_PWM     = 8'h0C;
    localparam logic [7:0] OFS_STG     = 8'h10;
    localparam logic [7:0] STG_STRIDE  = 8'h10;
    localparam logic [7:0] OFS_KP      = 8'h00;
    localparam logic [7:0] OFS_TN      = 8'h04;
    localparam logic [7:0] OFS_EMAX    = 8'h08;
    localparam logic [7:0] OFS_YMAX    = 8'h0C;
    localparam logic [7:0] OFS_FF_VEL  = 8'h40;
    localparam logic [7:0] OFS_FF_ACC  = 8'h44;
    localparam logic [7:0] OFS_INERTIA = 8'h48;
    localparam logic [7:0] OFS_FF_VOLT = 8'h4C;
    localparam logic [7:0] OFS_U_RATED = 8'h50;
    localparam logic [7:0] OFS_I_RATED = 8'h54;
    localparam logic [7:0] OFS_LEG     = 8'h60;
    localparam logic [7:0] LEG_STRIDE  = 8'h08;

    localparam int CTRL_EN_BIT      = 0;
    localparam int CTRL_POSLOOP_BIT = 1;
    localparam int CTRL_RTQ_BIT     = 5;
    localparam int CTRL_MODE_LSB    = 8;
    localparam int LEG_CL_BIT       = 0;
    localparam int LEG_OL_BIT       = 1;
    localparam int LEG_CLSEL_BIT    = 2;

    typedef enum logic [3:0] {
        CPM_MODE_PP   = 4'h0,
        CPM_MODE_VEL  = 4'h1,
        CPM_MODE_PV   = 4'h2,
        CPM_MODE_PT   = 4'h3,
        CPM_MODE_HOME = 4'h4,
        CPM_MODE_IP   = 4'h5,
        CPM_MODE_CSP  = 4'h6,
        CPM_MODE_CSV  = 4'h7,
        CPM_MODE_CST  = 4'h8,
        CPM_MODE_CD   = 4'h9
    } cpm_mode_e;

    typedef struct packed {
        logic [15:0] kp;
        logic [15:0] tn;
        logic [15:0] emax;
        logic [15:0] ymax;
    } cpm_pi_par_s;

    localparam logic [15:0] RST_CTRL    = 16'h0000;
    localparam logic [15:0] RST_LEGACY  = 16'h0007;
    localparam logic [15:0] RST_KP      = 16'h03E8;
    localparam logic [15:0] RST_TN      = 16'h0064;
    localparam logic [15:0] RST_EMAX    = 16'h03E8;
    localparam logic [15:0] RST_YMAX    = 16'h7FFF;
    localparam logic [15:0] RST_FF_VEL  = 16'h0000;
    localparam logic [15:0] RST_FF_ACC  = 16'h0000;
    localparam logic [15:0] RST_INERTIA = 16'h03E8;
    localparam logic [15:0] RST_FF_VOLT = 16'h03E8;
    localparam logic [15:0] RST_U_RATED = 16'h03E8;
    localparam logic [15:0] RST_I_RATED = 16'h03E8;
endpackage : cpm_pkg
`default_nettype wire

// ### core/cpm_ctrl.sv
/*
 * cpm_ctrl: cascaded position, velocity and current PI controllers
 * with three feed-forward paths and an Avalon-MM register slave.
 * Assumes set points and feedback are synchronous to i_core_clk and
 * stable across each control-cycle strobe.
 */
// What this block does
// - current controller runs in every operating mode.
// - velocity controller runs unless real-torque bit 5 is set in torque mode.
// - position loop on in PP, homing, IP, CSP and clock-direction.
// - position loop also on in velocity, PV, CSV when submode bit 1 set.
// - legacy set by default; new set when its closed/open flag is zero.
// - at switch-on legacy values are converted into the new set.
// - each stage is P plus I; its output is the next stage set point.
// - clamp to max speed only with position loop, max current only with velocity loop; PWM always clamped.
// - at 100 percent gain, deviation emax gives exactly ymax.
// - proportional output is linear in gain factor.
// - smaller reset time makes the integral grow faster.
// - reset time zero forces integral to zero.
// - velocity feed-forward is ramp velocity times permille factor.
// - velocity feed-forward only while the position loop is active.
// - acceleration feed-forward is ramp accel times inertia times factor.
// - acceleration feed-forward added before current loop except torque.
// - voltage feed-forward in permille of rated voltage, default 1000.
// - voltage feed-forward always on, off when factor is zero.
// - feed-forward enters in the same control cycle, unfiltered.
`default_nettype none
module cpm_ctrl #(
    parameter int CYCLE_CNT = cpm_pkg::CYCLE_CNT
) (
    input  wire logic               i_core_clk,
    input  wire logic               i_rst,
    input  wire logic [7:0]         i_avs_address,
    input  wire logic               i_avs_read,
    input  wire logic               i_avs_write,
    input  wire logic [31:0]        i_avs_writedata,
    input  wire logic [3:0]         i_avs_byteenable,
    output logic      [31:0]        o_avs_readdata,
    output logic                    o_avs_waitrequest,
    input  wire logic signed [15:0] i_pos_target,
    input  wire logic signed [15:0] i_vel_target,
    input  wire logic signed [15:0] i_tq_target,
    input  wire logic signed [15:0] i_ramp_vel,
    input  wire logic signed [15:0] i_ramp_acc,
    input  wire logic signed [15:0] i_pos_act,
    input  wire logic signed [15:0] i_vel_act,
    input  wire logic signed [15:0] i_cur_act,
    output logic signed [15:0]      o_vel_set,
    output logic signed [15:0]      o_cur_set,
    output logic signed [15:0]      o_pwm,
    output logic                    o_cycle
);
    localparam int NS = cpm_pkg::NSTAGE;

    function automatic logic signed [63:0] u64(input logic [15:0] x);
        u64 = $signed({48'h0, x});
    endfunction : u64

    // limit treated as a positive 15-bit magnitude so it fits the data path
    function automatic logic signed [15:0] sat16(
        input logic signed [63:0] x,
        input logic        [15:0] lim
    );
        logic signed [63:0] l;
        l = $signed({49'h0, lim[14:0]});
        if (x > l) begin
            sat16 = 16'(l);
        end else if (x < -l) begin
            sat16 = 16'(-l);
        end else begin
            sat16 = 16'(x);
        end
    endfunction : sat16

    function automatic logic signed [63:0] prop(
        input logic signed [63:0] e,
        input cpm_pkg::cpm_pi_par_s p
    );
        logic signed [63:0] num;
        logic signed [63:0] den;
        num = e * u64(p.ymax) * u64(p.kp);
        den = u64(p.emax) * cpm_pkg::PERMILLE;
        if (den == 64'sh0) begin
            prop = 64'sh0;
        end else begin
            prop = num / den;
        end
    endfunction : prop

    function automatic logic [15:0] be_merge(input logic [15:0] old);
        be_merge[7:0]  = i_avs_byteenable[0] ? i_avs_writedata[7:0]
                                             : old[7:0];
        be_merge[15:8] = i_avs_byteenable[1] ? i_avs_writedata[15:8]
                                             : old[15:8];
    endfunction : be_merge

    function automatic logic [7:0] stg_adr(input int k, input logic [7:0] o);
        stg_adr = 8'(cpm_pkg::OFS_STG + 8'(k) * cpm_pkg::STG_STRIDE + o);
    endfunction : stg_adr

    logic        ack_q;
    logic        wr_fire;
    logic        rd_take;
    logic [15:0] ctrl_q;
    logic [15:0] legacy_q;
    logic [15:0] ff_vel_q;
    logic [15:0] ff_acc_q;
    logic [15:0] inertia_q;
    logic [15:0] ff_volt_q;
    logic [15:0] u_rated_q;
    logic [15:0] i_rated_q;
    logic        conv_done_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [31:0] div_cnt_q;
    logic        tick;
    cpm_pkg::cpm_pi_par_s new_par_q [NS];
    cpm_pkg::cpm_pi_par_s leg_par_q [NS];
    cpm_pkg::cpm_pi_par_s par       [NS];
    logic signed [15:0] acc_q [NS];
    logic signed [15:0] sp    [NS];
    logic signed [15:0] fb    [NS];
    logic signed [15:0] y     [NS];
    logic               act   [NS];
    logic signed [63:0] ffv;
    logic signed [63:0] ffa;
    logic signed [63:0] ffu;
    logic signed [15:0] pwm_d;
    logic [3:0]  mode;
    logic        torque_mode;
    logic        vel_family;
    logic        pos_family;
    logic        pos_en;
    logic        vel_en;
    logic        use_new;

    // bus: one wait cycle for every access, then the answer
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
    assign wr_fire = i_avs_write & ack_q;
    assign rd_take = i_avs_read & ~ack_q;
    assign o_avs_readdata = rdata_q;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
        end
    end

    // control-cycle strobe from the core clock
    always_ff @(posedge i_core_clk) begin
        if (i_rst || div_cnt_q == 32'(CYCLE_CNT - 1)) begin
            div_cnt_q <= 32'h0;
        end else begin
            div_cnt_q <= div_cnt_q + 32'h1;
        end
    end
    assign tick = (div_cnt_q == 32'(CYCLE_CNT - 1));

    // mode decode
    assign mode = ctrl_q[cpm_pkg::CTRL_MODE_LSB +: 4];
    assign torque_mode = (mode == cpm_pkg::CPM_MODE_PT)
                       | (mode == cpm_pkg::CPM_MODE_CST);
    assign vel_family  = (mode == cpm_pkg::CPM_MODE_VEL)
                       | (mode == cpm_pkg::CPM_MODE_PV)
                       | (mode == cpm_pkg::CPM_MODE_CSV);
    assign pos_family  = (mode == cpm_pkg::CPM_MODE_PP)
                       | (mode == cpm_pkg::CPM_MODE_HOME)
                       | (mode == cpm_pkg::CPM_MODE_IP)
                       | (mode == cpm_pkg::CPM_MODE_CSP)
                       | (mode == cpm_pkg::CPM_MODE_CD);
    assign pos_en = pos_family
                  | (vel_family & ctrl_q[cpm_pkg::CTRL_POSLOOP_BIT]);
    assign vel_en = ~(torque_mode & ctrl_q[cpm_pkg::CTRL_RTQ_BIT]);
    assign use_new = legacy_q[cpm_pkg::LEG_CLSEL_BIT]
                   ? ~legacy_q[cpm_pkg::LEG_CL_BIT]
                   : ~legacy_q[cpm_pkg::LEG_OL_BIT];

    assign act[cpm_pkg::STG_POS] = pos_en;
    assign act[cpm_pkg::STG_VEL] = vel_en;
    assign act[cpm_pkg::STG_CUR] = 1'b1;
    assign fb[cpm_pkg::STG_POS] = i_pos_act;
    assign fb[cpm_pkg::STG_VEL] = i_vel_act;
    assign fb[cpm_pkg::STG_CUR] = i_cur_act;

    // feed-forward paths, combinational so they land in this cycle
    assign ffv = pos_en ? (u64(ff_vel_q) * 64'(i_ramp_vel))
                          / cpm_pkg::PERMILLE : 64'sh0;
    assign ffa = torque_mode ? 64'sh0
               : (64'(i_ramp_acc) * u64(inertia_q) * u64(ff_acc_q))
                 / cpm_pkg::PERMILLE;
    assign ffu = (ff_volt_q == 16'h0 || i_rated_q == 16'h0) ? 64'sh0
               : (64'(sp[cpm_pkg::STG_CUR]) * u64(u_rated_q)
                  * u64(ff_volt_q))
                 / (u64(i_rated_q) * cpm_pkg::PERMILLE);

    assign sp[cpm_pkg::STG_POS] = i_pos_target;
    assign sp[cpm_pkg::STG_VEL] = pos_en
        ? sat16(64'(y[cpm_pkg::STG_POS]) + ffv,
                par[cpm_pkg::STG_POS].ymax)
        : i_vel_target;
    // without the velocity loop the torque target drives current directly
    assign sp[cpm_pkg::STG_CUR] = vel_en
        ? sat16(64'(y[cpm_pkg::STG_VEL]) + ffa,
                par[cpm_pkg::STG_VEL].ymax)
        : i_tq_target;
    assign pwm_d = sat16(64'(y[cpm_pkg::STG_CUR]) + ffu,
                         par[cpm_pkg::STG_CUR].ymax);

    // per-stage PI: the divider chain is long but runs once per cycle
    for (genvar k = 0; k < NS; k++) begin : g_stage
        logic signed [63:0] err;
        logic signed [63:0] pterm;
        logic signed [63:0] iinc;
        assign par[k] = use_new ? new_par_q[k]
                      : '{kp: leg_par_q[k].kp, tn: leg_par_q[k].tn,
                          emax: new_par_q[k].emax,
                          ymax: new_par_q[k].ymax};
        assign err   = 64'(sp[k]) - 64'(fb[k]);
        assign pterm = prop(err, par[k]);
        assign iinc  = (par[k].tn == 16'h0) ? 64'sh0
                     : pterm / u64(par[k].tn);
        assign y[k]  = act[k]
                     ? sat16(pterm + 64'(acc_q[k]), par[k].ymax)
                     : 16'sh0;
        always_ff @(posedge i_core_clk) begin
            if (i_rst) begin
                acc_q[k] <= 16'sh0;
            end else if (tick) begin
                if (!act[k] || !ctrl_q[cpm_pkg::CTRL_EN_BIT]
                    || par[k].tn == 16'h0) begin
                    acc_q[k] <= 16'sh0;
                end else begin
                    acc_q[k] <= sat16(64'(acc_q[k]) + iinc,
                                      par[k].ymax);
                end
            end
        end
    end

    // outputs update on the control-cycle strobe only
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_vel_set <= 16'sh0;
            o_cur_set <= 16'sh0;
            o_pwm     <= 16'sh0;
            o_cycle   <= 1'b0;
        end else begin
            o_cycle <= tick;
            if (tick) begin
                if (ctrl_q[cpm_pkg::CTRL_EN_BIT]) begin
                    o_vel_set <= sp[cpm_pkg::STG_VEL];
                    o_cur_set <= sp[cpm_pkg::STG_CUR];
                    o_pwm     <= pwm_d;
                end else begin
                    o_vel_set <= 16'sh0;
                    o_cur_set <= 16'sh0;
                    o_pwm     <= 16'sh0;
                end
            end
        end
    end

    // scalar configuration registers
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            ctrl_q    <= cpm_pkg::RST_CTRL;
            legacy_q  <= cpm_pkg::RST_LEGACY;
            ff_vel_q  <= cpm_pkg::RST_FF_VEL;
            ff_acc_q  <= cpm_pkg::RST_FF_ACC;
            inertia_q <= cpm_pkg::RST_INERTIA;
            ff_volt_q <= cpm_pkg::RST_FF_VOLT;
            u_rated_q <= cpm_pkg::RST_U_RATED;
            i_rated_q <= cpm_pkg::RST_I_RATED;
        end else if (wr_fire) begin
            unique case (i_avs_address)
                cpm_pkg::OFS_CTRL:    ctrl_q    <= be_merge(ctrl_q);
                cpm_pkg::OFS_LEGACY:  legacy_q  <= be_merge(legacy_q);
                cpm_pkg::OFS_FF_VEL:  ff_vel_q  <= be_merge(ff_vel_q);
                cpm_pkg::OFS_FF_ACC:  ff_acc_q  <= be_merge(ff_acc_q);
                cpm_pkg::OFS_INERTIA: inertia_q <= be_merge(inertia_q);
                cpm_pkg::OFS_FF_VOLT: ff_volt_q <= be_merge(ff_volt_q);
                cpm_pkg::OFS_U_RATED: u_rated_q <= be_merge(u_rated_q);
                cpm_pkg::OFS_I_RATED: i_rated_q <= be_merge(i_rated_q);
                default: ;
            endcase
        end
    end

    // new parameter set; legacy values are converted once after reset
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            conv_done_q <= 1'b0;
            for (int k = 0; k < NS; k++) begin
                new_par_q[k] <= '{kp: cpm_pkg::RST_KP, tn: cpm_pkg::RST_TN,
                                  emax: cpm_pkg::RST_EMAX,
                                  ymax: cpm_pkg::RST_YMAX};
            end
        end else if (!conv_done_q) begin
            conv_done_q <= 1'b1;
            for (int k = 0; k < NS; k++) begin
                new_par_q[k].kp <= leg_par_q[k].kp;
                new_par_q[k].tn <= leg_par_q[k].tn;
            end
        end else if (wr_fire) begin
            for (int k = 0; k < NS; k++) begin
                if (i_avs_address == stg_adr(k, cpm_pkg::OFS_KP)) begin
                    new_par_q[k].kp <= be_merge(new_par_q[k].kp);
                end
                if (i_avs_address == stg_adr(k, cpm_pkg::OFS_TN)) begin
                    new_par_q[k].tn <= be_merge(new_par_q[k].tn);
                end
                if (i_avs_address == stg_adr(k, cpm_pkg::OFS_EMAX)) begin
                    new_par_q[k].emax <= be_merge(new_par_q[k].emax);
                end
                if (i_avs_address == stg_adr(k, cpm_pkg::OFS_YMAX)) begin
                    new_par_q[k].ymax <= be_merge(new_par_q[k].ymax);
                end
            end
        end
    end

    // legacy gain and reset time per stage
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            for (int k = 0; k < NS; k++) begin
                leg_par_q[k] <= '{kp: cpm_pkg::RST_KP, tn: cpm_pkg::RST_TN,
                                  emax: cpm_pkg::RST_EMAX,
                                  ymax: cpm_pkg::RST_YMAX};
            end
        end else if (wr_fire) begin
            for (int k = 0; k < NS; k++) begin
                if (i_avs_address == 8'(cpm_pkg::OFS_LEG
                        + 8'(k) * cpm_pkg::LEG_STRIDE)) begin
                    leg_par_q[k].kp <= be_merge(leg_par_q[k].kp);
                end
                if (i_avs_address == 8'(cpm_pkg::OFS_LEG
                        + 8'(k) * cpm_pkg::LEG_STRIDE + cpm_pkg::OFS_TN)) begin
                    leg_par_q[k].tn <= be_merge(leg_par_q[k].tn);
                end
            end
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        rdata_d = 32'h0;
        unique case (i_avs_address)
            cpm_pkg::OFS_CTRL:    rdata_d = {16'h0, ctrl_q};
            cpm_pkg::OFS_LEGACY:  rdata_d = {16'h0, legacy_q};
            cpm_pkg::OFS_STATUS:  rdata_d = {28'h0, use_new, vel_en,
                                             pos_en, conv_done_q};
            cpm_pkg::OFS_PWM:     rdata_d = {16'h0, o_pwm};
            cpm_pkg::OFS_FF_VEL:  rdata_d = {16'h0, ff_vel_q};
            cpm_pkg::OFS_FF_ACC:  rdata_d = {16'h0, ff_acc_q};
            cpm_pkg::OFS_INERTIA: rdata_d = {16'h0, inertia_q};
            cpm_pkg::OFS_FF_VOLT: rdata_d = {16'h0, ff_volt_q};
            cpm_pkg::OFS_U_RATED: rdata_d = {16'h0, u_rated_q};
            cpm_pkg::OFS_I_RATED: rdata_d = {16'h0, i_rated_q};
            default: ;
        endcase
        for (int k = 0; k < NS; k++) begin
            if (i_avs_address == stg_adr(k, cpm_pkg::OFS_KP)) begin
                rdata_d = {16'h0, new_par_q[k].kp};
            end
            if (i_avs_address == stg_adr(k, cpm_pkg::OFS_TN)) begin
                rdata_d = {16'h0, new_par_q[k].tn};
            end
            if (i_avs_address == stg_adr(k, cpm_pkg::OFS_EMAX)) begin
                rdata_d = {16'h0, new_par_q[k].emax};
            end
            if (i_avs_address == stg_adr(k, cpm_pkg::OFS_YMAX)) begin
                rdata_d = {16'h0, new_par_q[k].ymax};
            end
            if (i_avs_address == 8'(cpm_pkg::OFS_LEG
                    + 8'(k) * cpm_pkg::LEG_STRIDE)) begin
                rdata_d = {16'h0, leg_par_q[k].kp};
            end
            if (i_avs_address == 8'(cpm_pkg::OFS_LEG
                    + 8'(k) * cpm_pkg::LEG_STRIDE + cpm_pkg::OFS_TN)) begin
                rdata_d = {16'h0, leg_par_q[k].tn};
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            rdata_q <= 32'h0;
        end else if (rd_take) begin
            rdata_q <= rdata_d;
        end
    end
endmodule : cpm_ctrl
`default_nettype wire

// ### testbench/cpm_ctrl_checker.sv
/* cpm_ctrl_checker: port properties of cpm_ctrl.
   Assumes it is bound to cpm_ctrl, one core clock. */
`default_nettype none
module cpm_ctrl_checker #(
    parameter int CYCLE_CNT = 8
) (
    input wire logic               i_core_clk,
    input wire logic               i_rst,
    input wire logic [7:0]         i_avs_address,
    input wire logic               i_avs_read,
    input wire logic               i_avs_write,
    input wire logic [31:0]        o_avs_readdata,
    input wire logic               o_avs_waitrequest,
    input wire logic signed [15:0] o_vel_set,
    input wire logic signed [15:0] o_cur_set,
    input wire logic signed [15:0] o_pwm,
    input wire logic               o_cycle
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    logic [15:0] gap_q;
    logic        seen_q;
    wire logic   done = (i_avs_read || i_avs_write) && !o_avs_waitrequest;
    // gap counter: a long count would not unroll as a repetition
    always_ff @(posedge i_core_clk) begin
        if (i_rst || o_cycle) begin
            gap_q <= 16'h0;
        end else begin
            gap_q <= gap_q + 16'h1;
        end
    end
    always_ff @(posedge i_core_clk) begin
        seen_q <= i_rst ? 1'b0 : (seen_q | o_cycle);
    end
    AST_CYC_PULSE: assert property (o_cycle |=> !o_cycle)
        else $error("cycle pulse longer than one clock");
    AST_CYC_GAP: assert property (o_cycle && seen_q |->
        gap_q == CYCLE_CNT - 1) else $error("cycle spacing wrong");
    AST_RST_ZERO: assert property ($past(i_rst) |-> o_pwm == 0 &&
        o_cur_set == 0 && o_vel_set == 0) else $error("outputs not 0");
    AST_RD_WAIT: assert property ($rose(i_avs_read) |->
        o_avs_waitrequest ##1 !o_avs_waitrequest) else $error("rd wait");
    AST_WR_WAIT: assert property ($rose(i_avs_write) |->
        o_avs_waitrequest ##1 !o_avs_waitrequest) else $error("wr wait");
    AST_IDLE: assert property (!(i_avs_read || i_avs_write) |->
        !o_avs_waitrequest) else $error("wait without request");
    AST_UNMAP: assert property (done && i_avs_read && i_avs_address ==
        8'hFC |-> o_avs_readdata == 32'h0) else $error("unmapped read");
    AST_CONV: assert property (done && i_avs_read && !$past(i_rst, 2) &&
        i_avs_address == cpm_pkg::OFS_STATUS |-> o_avs_readdata[0])
        else $error("conversion flag low");
    cover property (o_cycle && o_pwm != 0);
    cover property (done && i_avs_write);
    cover property (done && i_avs_address == 8'hFC);
endmodule : cpm_ctrl_checker
bind cpm_ctrl cpm_ctrl_checker #(.CYCLE_CNT(CYCLE_CNT)) u_chk (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .o_vel_set(o_vel_set), .o_cur_set(o_cur_set), .o_pwm(o_pwm),
    .o_cycle(o_cycle));
`default_nettype wire

// ### testbench/cpm_motor_model.sv
/* cpm_motor_model: encoder and current feedback of the plant.
   Assumes the bench sets the plant state; it moves only on a cycle. */
`default_nettype none
module cpm_motor_model (
    input wire logic               i_core_clk,
    input wire logic               i_rst,
    input wire logic               i_cycle,
    input wire logic signed [15:0] i_set_pos,
    input wire logic signed [15:0] i_set_vel,
    input wire logic signed [15:0] i_set_cur,
    output logic signed [15:0]     o_pos_act,
    output logic signed [15:0]     o_vel_act,
    output logic signed [15:0]     o_cur_act
);
    // latched on the pulse so feedback is stable across the next strobe
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            {o_pos_act, o_vel_act, o_cur_act} <= 48'h0;
        end else if (i_cycle) begin
            {o_pos_act, o_vel_act, o_cur_act} <= {i_set_pos, i_set_vel,
                                                  i_set_cur};
        end
    end
endmodule : cpm_motor_model
`default_nettype wire

// ### testbench/cpm_ctrl_tb_top.sv
/* cpm_ctrl_tb_top: register and loop tests of cpm_ctrl.
   Assumes a short control cycle of 8 clocks. */
`default_nettype none
module cpm_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, rd = 0, wr = 0;
    logic [7:0] ad = 0;
    logic [31:0] wd = 0, q;
    logic signed [15:0] pt = 0, vt = 0, tt = 0, rv = 0, ra = 0, a;
    logic signed [15:0] fp = 0, fv = 0, fc = 0, pa, va, ca, vs, cs, pw;
    logic [31:0] rq;
    logic wq, cy;
    int n_mismatch = 0, check_count = 0, tmo = 0;
    always #2 clk = ~clk;
    cpm_ctrl #(.CYCLE_CNT(8)) uut (.i_core_clk(clk), .i_rst(rst),
        .i_avs_address(ad), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rq),
        .o_avs_waitrequest(wq), .i_pos_target(pt), .i_vel_target(vt),
        .i_tq_target(tt), .i_ramp_vel(rv), .i_ramp_acc(ra), .i_pos_act(pa),
        .i_vel_act(va), .i_cur_act(ca), .o_vel_set(vs), .o_cur_set(cs),
        .o_pwm(pw), .o_cycle(cy));
    cpm_motor_model u_mot (.i_core_clk(clk), .i_rst(rst), .i_cycle(cy),
        .i_set_pos(fp), .i_set_vel(fv), .i_set_cur(fc), .o_pos_act(pa),
        .o_vel_act(va), .o_cur_act(ca));
    task automatic end_sim;
        if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    always @(posedge clk) begin
        tmo <= tmo + 1;
        if (tmo == 6000) begin
            n_mismatch++;
            end_sim;
        end
    end
    task automatic chk(input string n, input logic [15:0] e, g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask : chk
    // request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic w, input logic [7:0] adr, input int d);
        @(posedge clk);
        rd <= !w; wr <= w; ad <= adr; wd <= d;
        do @(posedge clk); while (wq);
        q = rq;
        rd <= 0; wr <= 0;
    endtask : bus
    task automatic rc(input logic [7:0] adr, input logic [15:0] e);
        bus(0, adr, 0);
        chk("reg", e, q[15:0]);
    endtask : rc
    task automatic cyc(input int n);
        repeat (n) begin
            do @(posedge clk); while (!cy);
        end
    endtask : cyc
    function automatic logic [7:0] sa(input int k, input logic [7:0] o);
        return 8'(cpm_pkg::OFS_STG + cpm_pkg::STG_STRIDE * k + o);
    endfunction : sa
    initial begin
        repeat (8) @(posedge clk);
        rst <= 0;
        rc(cpm_pkg::OFS_CTRL, 16'h0);
        rc(cpm_pkg::OFS_LEGACY, 16'h7);
        rc(cpm_pkg::OFS_FF_VOLT, 16'h3E8);
        rc(8'hFC, 16'h0);
        rc(cpm_pkg::OFS_STATUS, 16'h7);
        bus(1, cpm_pkg::OFS_LEGACY, 4);
        bus(0, cpm_pkg::OFS_STATUS, 0);
        chk("new set", 1'b1, q[3]);
        for (int k = 0; k < 3; k++) begin
            bus(1, sa(k, cpm_pkg::OFS_TN), 0);
            bus(1, sa(k, cpm_pkg::OFS_YMAX), 16'h3E8);
        end
        tt <= 16'h64; fc <= 16'h28;
        bus(1, cpm_pkg::OFS_CTRL, 16'h0321);
        cyc(2);
        chk("pwm", 16'hA0, pw);
        chk("cur_set", 16'h64, cs);
        bus(1, cpm_pkg::OFS_FF_VOLT, 0);
        cyc(2);
        chk("pwm", 16'h3C, pw);
        bus(1, sa(2, cpm_pkg::OFS_KP), 16'h1F4);
        cyc(2);
        chk("pwm", 16'h1E, pw);
        bus(1, sa(2, cpm_pkg::OFS_KP), 16'h3E8);
        bus(1, sa(2, cpm_pkg::OFS_EMAX), 16'h3C);
        cyc(2);
        chk("pwm", 16'h3E8, pw);
        fc <= 16'h46;
        cyc(2);
        chk("pwm", 16'h1F4, pw);
        fc <= 16'h0;
        cyc(2);
        chk("pwm", 16'h3E8, pw);
        bus(1, sa(2, cpm_pkg::OFS_EMAX), 16'h3E8);
        bus(1, sa(2, cpm_pkg::OFS_TN), 2);
        cyc(2);
        a = pw;
        cyc(1);
        chk("step", 16'h32, pw - a);
        cyc(25);
        fc <= 16'hC8;
        cyc(2);
        chk("pwm", 16'h384, pw);
        bus(1, sa(2, cpm_pkg::OFS_TN), 0);
        cyc(2);
        chk("pwm", 16'hFF9C, pw);
        vt <= 16'h32; fv <= 16'h14; ra <= 16'hA;
        bus(1, cpm_pkg::OFS_INERTIA, 1);
        bus(1, cpm_pkg::OFS_FF_ACC, 16'h3E8);
        bus(1, cpm_pkg::OFS_CTRL, 16'h0101);
        cyc(2);
        chk("cur_set", 16'h28, cs);
        chk("vel_set", 16'h32, vs);
        bus(1, cpm_pkg::OFS_CTRL, 16'h0301);
        cyc(2);
        chk("cur_set", 16'h1E, cs);
        pt <= 16'h46; fp <= 16'h1E; rv <= 16'h14; vt <= 16'h7;
        bus(1, cpm_pkg::OFS_FF_VEL, 16'h1F4);
        for (int m = 0; m < 10; m++) begin
            for (int b = 0; b < 2; b++) begin
                if (m != 3 && m != 8) begin
                    bus(1, cpm_pkg::OFS_CTRL, (m << 8) | (b << 1) | 1);
                    cyc(2);
                    chk("vel_set", (m inside {1, 2, 7} && b == 0) ?
                        16'h7 : 16'h32, vs);
                end
            end
        end
        bus(1, cpm_pkg::OFS_CTRL, 0);
        repeat (20) @(posedge clk);
        chk("pwm", 16'h0, pw);
        end_sim;
    end
endmodule : cpm_ctrl_tb_top
`default_nettype wire
